// ---- rtl/mieu_top.sv ----
// mieu_top: instruction execute unit with ahb-lite register access
//
// Added by the designer: the address map and the AHB-Lite register port.
`default_nettype none
// Functional notes
// - add with carry
// - plain add of memory or immediate
// - and/or touch only the zero flag
// - call pushes pc plus one, two cycles
// - clear byte or single bit, no flags
// - watchdog clear zeroes counter, timeout and powered-down flags
// - invert byte, to memory or accumulator
// - decimal adjust into memory, carry only
// - decrement, zero flag only
// - increment, zero flag only
// - halt stops clock, sets powered-down flag
// - jump loads target, two cycles
// - moves change no flag
// - no-op only advances
// - return pops pc, optionally loads accumulator
// - interrupt return enables irqs, serves pending
// - rotate left wraps bit seven
module mieu_top
  import mieu_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  instValid,
  output logic                       instReady,
  input  wire mieu_pkg::mieu_op_t    instOp,
  input  wire logic [7:0]            instImm,
  input  wire logic [2:0]            instBit,
  input  wire logic [PC_W-1:0]       instTarget,
  input  wire logic [PC_W-1:0]       pcCurrent,
  output logic                       instDone,
  output logic                       pcLoadEn,
  output logic [PC_W-1:0]            pcLoadAddr,
  output logic                       irqServe,
  input  wire logic                  irqPending,
  output logic                       sysClkRun,
  input  wire logic                  wakeIn,
  input  wire logic [7:0]            memRdData,
  output logic                       memWrEn,
  output logic [7:0]                 memWrData,
  output logic                       stackPush,
  output logic [PC_W-1:0]            stackPushData,
  output logic                       stackPop,
  input  wire logic [PC_W-1:0]       stackTop,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp
);

  // ==========================================================================
  // state
  typedef struct packed {
    mieu_state_t     fsm;
    logic [7:0]      accum;
    logic            fCarry;
    logic            fAux;
    logic            fZero;
    logic            fOverflow;
    logic            fSignCmp;
    logic            fTimeout;
    logic            fPwrDown;
    logic            irqEnable;
    logic [7:0]      wdogPresc;
    logic [7:0]      wdogCount;
    logic            memWrEn;
    logic [7:0]      memWrData;
    logic            pcLoadEn;
    logic [PC_W-1:0] pcLoadAddr;
    logic            push;
    logic [PC_W-1:0] pushData;
    logic            pop;
    logic            irqServe;
    logic            done;
    logic            busWrPend;
    logic [7:0]      busAddr;
    logic [31:0]     rdData;
  } mieu_regs_t;
  mieu_regs_t state_reg;
  mieu_regs_t state_next;
  mieu_alu_t  aluFunc;
  logic [7:0] aluA;
  logic [7:0] aluB;
  logic       aluCin;
  logic [7:0] aluRes;
  logic       aluCarry;
  logic       aluAux;
  logic       aluOverflow;
  logic       aluSignCmp;
  logic       aluZero;
  logic       take;
  logic       addrPhase;
  logic [7:0] flagsView;
  mieu_alu u_alu (
    .func        (aluFunc),
    .opA         (aluA),
    .opB         (aluB),
    .carryIn     (aluCin),
    .auxIn       (state_reg.fAux),
    .bitSel      (instBit),
    .result      (aluRes),
    .carryOut    (aluCarry),
    .auxOut      (aluAux),
    .overflowOut (aluOverflow),
    .signCmpOut  (aluSignCmp),
    .zeroOut     (aluZero)
  );
  // ==========================================================================
  // operand routing
  always_comb begin
    aluFunc = ALU_PASS;
    aluA    = memRdData;
    aluB    = memRdData;
    aluCin  = 1'b0;
    // relies on the encoding: codes up to or-to-memory use the accumulator
    if (instOp <= OP_OR_MEM || instOp == OP_DEC_ADJUST) begin
      aluA = state_reg.accum;
    end
    if (instOp inside {OP_ADD_IMM, OP_AND_IMM, OP_OR_IMM}) begin
      aluB = instImm;
    end
    case (instOp)
      OP_ADD_CARRY_ACC, OP_ADD_CARRY_MEM: begin
        aluFunc = ALU_ADD;
        aluCin  = state_reg.fCarry;
      end
      OP_ADD_ACC, OP_ADD_MEM, OP_ADD_IMM: aluFunc = ALU_ADD;
      OP_AND_ACC, OP_AND_MEM, OP_AND_IMM: aluFunc = ALU_AND;
      OP_OR_ACC, OP_OR_MEM, OP_OR_IMM:    aluFunc = ALU_OR;
      OP_INVERT_MEM, OP_INVERT_ACC:       aluFunc = ALU_INVERT;
      OP_INC_MEM, OP_INC_ACC:             aluFunc = ALU_INC;
      OP_DEC_MEM, OP_DEC_ACC:             aluFunc = ALU_DEC;
      OP_ROTATE_LEFT:                     aluFunc = ALU_ROTL;
      OP_CLEAR_BIT:                       aluFunc = ALU_CLRBIT;
      OP_DEC_ADJUST: begin
        aluFunc = ALU_DECADJ;
        aluCin  = state_reg.fCarry;
      end
      default: aluFunc = ALU_PASS;
    endcase
  end
  assign instReady = (state_reg.fsm == ST_IDLE);
  assign take      = instValid && instReady;
  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign flagsView = {state_reg.fsm == ST_HALTED, state_reg.fPwrDown, state_reg.fTimeout,
                      state_reg.fSignCmp, state_reg.fOverflow, state_reg.fZero,
                      state_reg.fAux, state_reg.fCarry};
  // ==========================================================================
  // next state
  always_comb begin
    state_next          = state_reg;
    state_next.memWrEn  = 1'b0;
    state_next.pcLoadEn = 1'b0;
    state_next.push     = 1'b0;
    state_next.pop      = 1'b0;
    state_next.irqServe = 1'b0;
    state_next.done     = 1'b0;
    // watchdog keeps counting in every state; a timeout also wakes from halt
    state_next.wdogPresc = state_reg.wdogPresc + 8'h01;
    if (state_reg.wdogPresc == WDOG_PRESC_MAX) begin
      state_next.wdogCount = state_reg.wdogCount + 8'h01;
      if (state_reg.wdogCount == WDOG_COUNT_MAX) begin
        state_next.fTimeout = 1'b1;
      end
    end
    case (state_reg.fsm)
      ST_IDLE: begin
        if (take) begin
          state_next.done = 1'b1;
          case (instOp)
            OP_ADD_CARRY_ACC, OP_ADD_CARRY_MEM, OP_ADD_ACC, OP_ADD_IMM, OP_ADD_MEM: begin
              state_next.fCarry    = aluCarry;
              state_next.fAux      = aluAux;
              state_next.fOverflow = aluOverflow;
              state_next.fSignCmp  = aluSignCmp;
              state_next.fZero     = aluZero;
            end
            OP_AND_ACC, OP_AND_IMM, OP_AND_MEM, OP_OR_ACC, OP_OR_IMM, OP_OR_MEM,
            OP_INVERT_MEM, OP_INVERT_ACC, OP_INC_MEM, OP_INC_ACC,
            OP_DEC_MEM, OP_DEC_ACC: begin
              state_next.fZero = aluZero;
            end
            OP_DEC_ADJUST: state_next.fCarry = aluCarry;
            default: state_next.fZero = state_reg.fZero;
          endcase
          case (instOp)
            OP_ADD_CARRY_ACC, OP_ADD_ACC, OP_ADD_IMM, OP_AND_ACC, OP_AND_IMM,
            OP_OR_ACC, OP_OR_IMM, OP_INVERT_ACC, OP_INC_ACC, OP_DEC_ACC,
            OP_MOVE_MEM_ACC: begin
              state_next.accum = aluRes;
            end
            OP_ADD_CARRY_MEM, OP_ADD_MEM, OP_AND_MEM, OP_OR_MEM, OP_INVERT_MEM,
            OP_INC_MEM, OP_DEC_MEM, OP_DEC_ADJUST, OP_ROTATE_LEFT, OP_CLEAR_BIT: begin
              state_next.memWrEn   = 1'b1;
              state_next.memWrData = aluRes;
            end
            OP_CLEAR_MEM: begin
              state_next.memWrEn   = 1'b1;
              state_next.memWrData = 8'h00;
            end
            OP_MOVE_ACC_MEM: begin
              state_next.memWrEn   = 1'b1;
              state_next.memWrData = state_reg.accum;
            end
            OP_MOVE_IMM_ACC: state_next.accum = instImm;
            OP_CALL: begin
              state_next.push       = 1'b1;
              state_next.pushData   = pcCurrent + PC_W'(1);
              state_next.pcLoadEn   = 1'b1;
              state_next.pcLoadAddr = instTarget;
              state_next.done       = 1'b0;
              state_next.fsm        = ST_SECOND;
            end
            OP_JUMP: begin
              state_next.pcLoadEn   = 1'b1;
              state_next.pcLoadAddr = instTarget;
              state_next.done       = 1'b0;
              state_next.fsm        = ST_SECOND;
            end
            OP_RETURN, OP_RETURN_IMM, OP_RETURN_IRQ: begin
              state_next.pop        = 1'b1;
              state_next.pcLoadEn   = 1'b1;
              state_next.pcLoadAddr = stackTop;
              if (instOp == OP_RETURN_IMM) begin
                state_next.accum = instImm;
              end
              if (instOp == OP_RETURN_IRQ) begin
                state_next.irqEnable = 1'b1;
                state_next.irqServe  = irqPending;
              end
            end
            OP_CLEAR_WDOG: begin
              state_next.wdogPresc = 8'h00;
              state_next.wdogCount = 8'h00;
              state_next.fTimeout  = 1'b0;
              state_next.fPwrDown  = 1'b0;
            end
            OP_HALT: begin
              state_next.wdogPresc = 8'h00;
              state_next.wdogCount = 8'h00;
              state_next.fTimeout  = 1'b0;
              state_next.fPwrDown  = 1'b1;
              state_next.fsm       = ST_HALTED;
            end
            default: state_next.fsm = ST_IDLE;
          endcase
        end
      end
      ST_SECOND: begin
        // dummy cycle while the sequencer loads the new address
        state_next.done = 1'b1;
        state_next.fsm  = ST_IDLE;
      end
      ST_HALTED: begin
        if (wakeIn || state_next.fTimeout) begin
          state_next.fsm = ST_IDLE;
        end
      end
      default: state_next.fsm = ST_IDLE;
    endcase
    // read data captured at the address phase, writes land a cycle later
    state_next.busWrPend = addrPhase && hwrite;
    if (addrPhase) begin
      state_next.busAddr = haddr[7:0];
      if (haddr[7:0] == ACCUM_OFFSET) begin
        state_next.rdData = {24'h000000, state_reg.accum};
      end else if (haddr[7:0] == FLAGS_OFFSET) begin
        state_next.rdData = {24'h000000, flagsView};
      end else if (haddr[7:0] == CTRL_OFFSET) begin
        state_next.rdData = {31'h00000000, state_reg.irqEnable};
      end else if (haddr[7:0] == WDOG_OFFSET) begin
        state_next.rdData = {24'h000000, state_reg.wdogCount};
      end else begin
        state_next.rdData = 32'h00000000;
      end
    end
    // bus write lands last, so software wins a tie
    if (state_reg.busWrPend) begin
      if (state_reg.busAddr == ACCUM_OFFSET) begin
        state_next.accum = hwdata[7:0];
      end else if (state_reg.busAddr == FLAGS_OFFSET) begin
        state_next.fCarry    = hwdata[FLAG_CARRY];
        state_next.fAux      = hwdata[FLAG_AUXCARRY];
        state_next.fZero     = hwdata[FLAG_ZERO];
        state_next.fOverflow = hwdata[FLAG_OVERFLOW];
        state_next.fSignCmp  = hwdata[FLAG_SIGNCMP];
      end else if (state_reg.busAddr == CTRL_OFFSET) begin
        state_next.irqEnable = hwdata[CTRL_IRQ_EN];
        if (hwdata[CTRL_WAKE] && state_reg.fsm == ST_HALTED) begin
          state_next.fsm = ST_IDLE;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg           <= '0;
      state_reg.fsm       <= ST_IDLE;
      state_reg.accum     <= ACCUM_RESET;
      state_reg.irqEnable <= IRQ_EN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end
  // ==========================================================================
  // outputs
  assign instDone      = state_reg.done;
  assign pcLoadEn      = state_reg.pcLoadEn;
  assign pcLoadAddr    = state_reg.pcLoadAddr;
  assign irqServe      = state_reg.irqServe;
  assign sysClkRun     = (state_reg.fsm != ST_HALTED);
  assign memWrEn       = state_reg.memWrEn;
  assign memWrData     = state_reg.memWrData;
  assign stackPush     = state_reg.push;
  assign stackPushData = state_reg.pushData;
  assign stackPop      = state_reg.pop;
  assign hrdata        = state_reg.rdData;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  // upper address and data bits are ignored
  logic unusedBits;
  assign unusedBits = ^{hsize, haddr[31:8], hwdata[31:8]};
endmodule
`default_nettype wire

// ---- rtl/mieu_pkg.sv ----
// mieu_pkg: constants and codes of the execute unit
`default_nettype none
package mieu_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int PC_W   = 12;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ACCUM_OFFSET = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_OFFSET  = 8'h08;
  localparam logic [7:0] WDOG_OFFSET  = 8'h0c;

  // flags register fields
  localparam int FLAG_CARRY    = 0;
  localparam int FLAG_AUXCARRY = 1;
  localparam int FLAG_ZERO     = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_SIGNCMP  = 4;
  localparam int FLAG_TIMEOUT  = 5;
  localparam int FLAG_PWRDOWN  = 6;
  localparam int FLAG_HALTED   = 7;

  // control register fields
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_WAKE   = 1;

  // ==========================================================================
  // reset values and counts
  localparam logic [7:0] ACCUM_RESET    = 8'h00;
  localparam logic       IRQ_EN_RESET   = 1'b0;
  localparam logic [7:0] WDOG_PRESC_MAX = 8'hff;
  localparam logic [7:0] WDOG_COUNT_MAX = 8'hff;

  // ==========================================================================
  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // ==========================================================================
  // instruction codes from the sequencer
  typedef enum logic [4:0] {
    OP_ADD_CARRY_ACC = 5'h00,
    OP_ADD_CARRY_MEM = 5'h01,
    OP_ADD_ACC       = 5'h02,
    OP_ADD_IMM       = 5'h03,
    OP_ADD_MEM       = 5'h04,
    OP_AND_ACC       = 5'h05,
    OP_AND_IMM       = 5'h06,
    OP_AND_MEM       = 5'h07,
    OP_OR_ACC        = 5'h08,
    OP_OR_IMM        = 5'h09,
    OP_OR_MEM        = 5'h0a,
    OP_CALL          = 5'h0b,
    OP_CLEAR_MEM     = 5'h0c,
    OP_CLEAR_BIT     = 5'h0d,
    OP_CLEAR_WDOG    = 5'h0e,
    OP_INVERT_MEM    = 5'h0f,
    OP_INVERT_ACC    = 5'h10,
    OP_DEC_ADJUST    = 5'h11,
    OP_DEC_MEM       = 5'h12,
    OP_DEC_ACC       = 5'h13,
    OP_INC_MEM       = 5'h14,
    OP_INC_ACC       = 5'h15,
    OP_HALT          = 5'h16,
    OP_JUMP          = 5'h17,
    OP_MOVE_MEM_ACC  = 5'h18,
    OP_MOVE_IMM_ACC  = 5'h19,
    OP_MOVE_ACC_MEM  = 5'h1a,
    OP_NO_OP         = 5'h1b,
    OP_RETURN        = 5'h1c,
    OP_RETURN_IMM    = 5'h1d,
    OP_RETURN_IRQ    = 5'h1e,
    OP_ROTATE_LEFT   = 5'h1f
  } mieu_op_t;

  // datapath functions
  typedef enum logic [3:0] {
    ALU_ADD    = 4'h0,
    ALU_AND    = 4'h1,
    ALU_OR     = 4'h2,
    ALU_INVERT = 4'h3,
    ALU_INC    = 4'h4,
    ALU_DEC    = 4'h5,
    ALU_DECADJ = 4'h6,
    ALU_ROTL   = 4'h7,
    ALU_PASS   = 4'h8,
    ALU_CLRBIT = 4'h9
  } mieu_alu_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SECOND = 2'b01,
    ST_HALTED = 2'b10
  } mieu_state_t;

endpackage
`default_nettype wire

// ---- rtl/mieu_alu.sv ----
// mieu_alu: combinational 8-bit datapath with arithmetic flags
`default_nettype none
module mieu_alu
  import mieu_pkg::*;
(
  input  wire mieu_pkg::mieu_alu_t func,
  input  wire logic [7:0]          opA,
  input  wire logic [7:0]          opB,
  input  wire logic                carryIn,
  input  wire logic                auxIn,
  input  wire logic [2:0]          bitSel,
  output logic [7:0]               result,
  output logic                     carryOut,
  output logic                     auxOut,
  output logic                     overflowOut,
  output logic                     signCmpOut,
  output logic                     zeroOut
);

  logic [4:0] lowSum;
  logic [8:0] fullSum;
  logic [8:0] adjSum;
  logic [7:0] adjVal;

  always_comb begin
    lowSum   = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    fullSum  = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
    // adjust tests the nibbles as they stand, before any correction
    adjVal   = {((opA[7:4] > 4'h9) || carryIn) ? 4'h6 : 4'h0,
                ((opA[3:0] > 4'h9) || auxIn) ? 4'h6 : 4'h0};
    adjSum   = {1'b0, opA} + {1'b0, adjVal};
    result   = opA;
    carryOut = carryIn;
    case (func)
      ALU_ADD: begin
        result   = fullSum[7:0];
        carryOut = fullSum[8];
      end
      ALU_AND:    result = opA & opB;
      ALU_OR:     result = opA | opB;
      ALU_INVERT: result = ~opA;
      ALU_INC:    result = opA + 8'h01;
      ALU_DEC:    result = opA - 8'h01;
      ALU_DECADJ: begin
        result   = adjSum[7:0];
        carryOut = carryIn | adjSum[8];
      end
      ALU_ROTL:   result = {opA[6:0], opA[7]};
      ALU_CLRBIT: result = opA & ~(8'h01 << bitSel);
      default:    result = opA;
    endcase
    auxOut      = lowSum[4];
    overflowOut = (opA[7] == opB[7]) && (fullSum[7] != opA[7]);
    signCmpOut  = overflowOut ^ fullSum[7];
    zeroOut     = (result == 8'h00);
  end

endmodule
`default_nettype wire

// ---- verification/mieu_checker.sv ----
// mieu_checker: port-level assertions for the instruction execute unit
`default_nettype none
module mieu_checker (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      instValid,
  input wire logic                      instReady,
  input wire mieu_pkg::mieu_op_t        instOp,
  input wire logic [2:0]                instBit,
  input wire logic [mieu_pkg::PC_W-1:0] instTarget,
  input wire logic [mieu_pkg::PC_W-1:0] pcCurrent,
  input wire logic                      instDone,
  input wire logic                      pcLoadEn,
  input wire logic [mieu_pkg::PC_W-1:0] pcLoadAddr,
  input wire logic                      irqServe,
  input wire logic                      irqPending,
  input wire logic                      sysClkRun,
  input wire logic [7:0]                memRdData,
  input wire logic                      memWrEn,
  input wire logic [7:0]                memWrData,
  input wire logic                      stackPush,
  input wire logic [mieu_pkg::PC_W-1:0] stackPushData,
  input wire logic                      stackPop,
  input wire logic [mieu_pkg::PC_W-1:0] stackTop
);
  timeunit 1ns;
  timeprecision 1ps;
  import mieu_pkg::*;
  // ==========================================================
  // operand views as seen at the accepting edge
  logic       tk;
  logic [7:0] clrV;
  logic [7:0] rotV;
  logic [7:0] stepV;
  assign tk    = instValid && instReady;
  assign clrV  = memRdData & ~(8'h01 << instBit);
  assign rotV  = {memRdData[6:0], memRdData[7]};
  assign stepV = (instOp == OP_INC_MEM) ? memRdData + 8'h01 : memRdData - 8'h01;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // a refused dummy cycle, then completion
  sequence s_dummy;
    !instReady && !instDone ##1 instReady && instDone;
  endsequence
  // ==========================================================
  // assertions
  AST_CALL: assert property (tk && instOp == OP_CALL |=>
    (stackPush && pcLoadEn && stackPushData == $past(pcCurrent) + 12'h001
     && pcLoadAddr == $past(instTarget)) ##0 s_dummy) else $error("call wrong");
  AST_JUMP: assert property (tk && instOp == OP_JUMP |=>
    (pcLoadEn && !stackPush && pcLoadAddr == $past(instTarget)) ##0 s_dummy)
    else $error("jump wrong");
  AST_ONE_CYC: assert property (tk && !(instOp inside {OP_CALL, OP_JUMP}) |=> instDone)
    else $error("op not done in one cycle");
  AST_CLEAR: assert property (tk && instOp == OP_CLEAR_MEM |=> memWrEn && memWrData == 8'h00)
    else $error("clear wrong");
  AST_CLR_BIT: assert property (tk && instOp == OP_CLEAR_BIT |=>
    memWrEn && memWrData == $past(clrV)) else $error("bit clear wrong");
  AST_ROTL: assert property (tk && instOp == OP_ROTATE_LEFT |=>
    memWrEn && memWrData == $past(rotV)) else $error("rotate wrong");
  AST_INVERT: assert property (tk && instOp == OP_INVERT_MEM |=>
    memWrEn && memWrData == ~$past(memRdData)) else $error("invert wrong");
  AST_STEP: assert property (tk && instOp inside {OP_INC_MEM, OP_DEC_MEM} |=>
    memWrEn && memWrData == $past(stepV)) else $error("step wrong");
  AST_NO_WRITE: assert property (tk && instOp inside {OP_INC_ACC, OP_DEC_ACC,
    OP_INVERT_ACC, OP_MOVE_MEM_ACC, OP_NO_OP} |=> !memWrEn && !stackPush && !stackPop
    && !pcLoadEn) else $error("unexpected side effect");
  AST_HALT: assert property (tk && instOp == OP_HALT |=> !sysClkRun && !instReady)
    else $error("halt wrong");
  AST_RET: assert property (tk && instOp inside {OP_RETURN, OP_RETURN_IMM} |=>
    stackPop && pcLoadEn && pcLoadAddr == $past(stackTop)) else $error("return wrong");
  AST_RETURN_FROM_IRQ: assert property (tk && instOp == OP_RETURN_IRQ |=>
    stackPop && irqServe == $past(irqPending)) else $error("irq return wrong");
endmodule
bind mieu_top mieu_checker u_mieu_checker (.*);
`default_nettype wire

// ---- verification/mieu_partner.sv ----
// mieu_partner: data memory byte, return stack and program counter
`default_nettype none
module mieu_partner (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      memWrEn,
  input  wire logic [7:0]                memWrData,
  output logic [7:0]                     memRdData,
  input  wire logic                      stackPush,
  input  wire logic [mieu_pkg::PC_W-1:0] stackPushData,
  input  wire logic                      stackPop,
  output logic [mieu_pkg::PC_W-1:0]      stackTop,
  input  wire logic                      pcLoadEn,
  input  wire logic [mieu_pkg::PC_W-1:0] pcLoadAddr,
  output logic [mieu_pkg::PC_W-1:0]      pcNow
);
  timeunit 1ns;
  timeprecision 1ps;
  import mieu_pkg::*;
  // ==========================================================
  // eight-deep stack, wraps silently
  logic [7:0]      memByte;
  logic [PC_W-1:0] stk [8];
  logic [2:0]      sp;
  assign memRdData = memByte;
  assign stackTop  = stk[sp - 3'h1];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memByte <= 8'h00;
      sp      <= 3'h0;
      pcNow   <= '0;
    end else begin
      if (memWrEn)
        memByte <= memWrData;
      if (stackPush) begin
        stk[sp] <= stackPushData;
        sp      <= sp + 3'h1;
      end else if (stackPop)
        sp <= sp - 3'h1;
      if (pcLoadEn)
        pcNow <= pcLoadAddr;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb_mcu_instruction_execute_unit.sv ----
// tb_mcu_instruction_execute_unit: directed instruction and bus tests
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errCount++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_mcu_instruction_execute_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import mieu_pkg::*;
  // ==========================================================
  // signals
  logic            clk = 1'b0, rst_n = 1'b0, instValid = 1'b0, irqPending = 1'b0;
  logic            wakeIn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  mieu_op_t        instOp = OP_NO_OP;
  logic [7:0]      instImm = 8'h00;
  logic [2:0]      instBit = 3'h0, hsize = 3'h2;
  logic [1:0]      htrans = 2'h0;
  logic [31:0]     haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [PC_W-1:0] instTarget = '0, pcCurrent, pcLoadAddr, stackPushData, stackTop;
  logic [7:0]      memRdData, memWrData;
  logic            instReady, instDone, pcLoadEn, irqServe, sysClkRun, memWrEn;
  logic            stackPush, stackPop, hready, hreadyout, hresp;
  int              errCount = 0, checks = 0;
  assign hready = hreadyout;
  mieu_top u_mieu_top (.*);
  mieu_partner u_mieu_partner (.*, .pcNow(pcCurrent));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // access tasks
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // two idle edges cover the call/jump dummy cycle
  task automatic issue(input mieu_op_t op, input logic [7:0] im, input logic [PC_W-1:0] tg);
    @(posedge clk);
    instValid  <= 1'b1;
    instOp     <= op;
    instImm    <= im;
    instBit    <= im[2:0];
    instTarget <= tg;
    do @(posedge clk); while (instReady !== 1'b1);
    instValid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // v: acc flags mem imm, then expected acc flags mem
  task automatic tc(input mieu_op_t op, input logic [55:0] v);
    ahb(1'b1, ACCUM_OFFSET, {24'h0, v[39:32]}, r);
    issue(OP_MOVE_ACC_MEM, 8'h00, '0);
    ahb(1'b1, ACCUM_OFFSET, {24'h0, v[55:48]}, r);
    ahb(1'b1, FLAGS_OFFSET, {24'h0, v[47:40]}, r);
    issue(op, v[31:24], '0);
    ahb(1'b0, ACCUM_OFFSET, 32'h0, r);
    `CHK(r, {24'h0, v[23:16]})
    ahb(1'b0, FLAGS_OFFSET, 32'h0, r);
    `CHK(r, {24'h0, v[15:8]})
    `CHK(u_mieu_partner.memByte, v[7:0])
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b1, 8'h10, 32'hffffffff, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    tc(OP_ADD_CARRY_ACC, 56'h7f010100810a01);
    tc(OP_ADD_CARRY_MEM, 56'h80018000801901);
    tc(OP_ADD_MEM,       56'h08010800080210);
    tc(OP_ADD_IMM,       56'hff000001000700);
    tc(OP_ADD_ACC,       56'h50015000a00850);
    tc(OP_AND_ACC,       56'hf01b0f00001f0f);
    tc(OP_AND_IMM,       56'h3c04000f0c0000);
    tc(OP_AND_MEM,       56'haa01f000aa01a0);
    tc(OP_OR_ACC,        56'h00000000000400);
    tc(OP_OR_IMM,        56'h01040080810000);
    tc(OP_OR_MEM,        56'h0f0b30000f0b3f);
    tc(OP_CLEAR_MEM,     56'h111fa500111f00);
    tc(OP_CLEAR_BIT,     56'h2204ff0722047f);
    tc(OP_CLEAR_BIT,     56'h00000100000000);
    tc(OP_INVERT_MEM,    56'h5a01ff005a0500);
    tc(OP_INVERT_ACC,    56'h00040f00f0000f);
    tc(OP_DEC_ADJUST,    56'h3a0200003a0240);
    tc(OP_DEC_ADJUST,    56'ha5000000a50105);
    tc(OP_DEC_ADJUST,    56'h12030000120378);
    tc(OP_DEC_ADJUST,    56'h45000000450045);
    tc(OP_DEC_MEM,       56'h33190100331d00);
    tc(OP_DEC_ACC,       56'h00040000ff0000);
    tc(OP_INC_MEM,       56'h0000ff00000400);
    tc(OP_INC_ACC,       56'h000c7f0080087f);
    tc(OP_MOVE_MEM_ACC,  56'h55000000000000);
    tc(OP_MOVE_IMM_ACC,  56'h001f00c3c31f00);
    tc(OP_MOVE_ACC_MEM,  56'h00007700000000);
    tc(OP_NO_OP,         56'h44136600441366);
    tc(OP_ROTATE_LEFT,   56'h00018100000103);
    issue(OP_CALL, 8'h00, 12'h123);
    `CHK(pcCurrent, 12'h123)
    `CHK(stackTop, 12'h001)
    issue(OP_JUMP, 8'h00, 12'hfff);
    `CHK(pcCurrent, 12'hfff)
    `CHK(stackTop, 12'h001)
    issue(OP_RETURN, 8'h00, '0);
    `CHK(pcCurrent, 12'h001)
    issue(OP_CALL, 8'h00, 12'h0aa);
    tc(OP_RETURN_IMM,    56'h0000009c9c0000);
    `CHK(pcCurrent, 12'h002)
    issue(OP_CALL, 8'h00, 12'h0f0);
    irqPending <= 1'b1;
    issue(OP_RETURN_IRQ, 8'h00, '0);
    ahb(1'b0, CTRL_OFFSET, 32'h0, r);
    `CHK(r, 32'h1)
    issue(OP_HALT, 8'h00, '0);
    `CHK(sysClkRun, 1'b0)
    ahb(1'b0, FLAGS_OFFSET, 32'h0, r);
    `CHK(r[7:5], 3'b110)
    wakeIn <= 1'b1;
    @(posedge clk);
    wakeIn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(instReady, 1'b1)
    issue(OP_CLEAR_WDOG, 8'h00, '0);
    ahb(1'b0, FLAGS_OFFSET, 32'h0, r);
    `CHK(r[7:5], 3'b000)
    ahb(1'b1, WDOG_OFFSET, 32'hff, r);
    ahb(1'b0, WDOG_OFFSET, 32'h0, r);
    `CHK(r, 32'h0)
    wrap_up();
  end
  // ==========================================================
  // hang guard, far beyond what the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    wrap_up();
  end
endmodule
`default_nettype wire
